//--- bench/tcm_drive_model.sv
// drive side model: takes write bytes, returns four read bytes, ends each operation
// assumes drv_start pulses once per read or write command
`timescale 1ns/1ps
module tcm_drive_model (
    input wire logic clk,
    input wire logic drv_start,
    input wire logic drv_dir_wr,
    input wire logic drv_wr_valid,
    input wire logic [8:0] drv_wr_data,
    input wire logic stall,
    input wire logic rd_bad,
    output logic drv_wr_ready,
    output logic drv_rd_valid,
    output logic [8:0] drv_rd_data,
    output logic drv_rd_last,
    output logic drv_op_done,
    output logic [7:0] wr_cnt,
    output logic [7:0] bad_cnt
);
    int idle;
    logic [7:0] b;
    initial begin
        drv_wr_ready = 1'b0;
        drv_rd_valid = 1'b0;
        drv_rd_data = 9'h155;
        drv_rd_last = 1'b0;
        drv_op_done = 1'b0;
        wr_cnt = 8'h00;
        bad_cnt = 8'h00;
    end
    always @(posedge clk) begin
        if (drv_start === 1'b1) begin
            idle = 0;
            if (drv_dir_wr) begin
                wr_cnt = 8'h00;
                bad_cnt = 8'h00;
                while (idle < 20) begin
                    drv_wr_ready <= !stall;
                    @(posedge clk);
                    idle = drv_wr_valid ? 0 : idle + 1;
                    if (drv_wr_valid && drv_wr_ready) begin
                        wr_cnt = wr_cnt + 8'h01;
                        bad_cnt = bad_cnt + {7'h00, !(^drv_wr_data)};
                    end
                end
                drv_wr_ready <= 1'b0;
            end else begin
                for (int i = 0; i < 4; i++) begin
                    repeat (3) @(posedge clk);
                    b = 8'hA0 + i[7:0];
                    drv_rd_valid <= 1'b1;
                    drv_rd_data <= {~^b ^ (rd_bad && i == 1), b};
                    drv_rd_last <= (i == 3);
                    @(posedge clk);
                    drv_rd_valid <= 1'b0;
                    drv_rd_data <= ~drv_rd_data;
                    drv_rd_last <= 1'b0;
                end
            end
            @(posedge clk);
            drv_op_done <= 1'b1;
            @(posedge clk);
            drv_op_done <= 1'b0;
        end
    end
endmodule : tcm_drive_model

//--- bench/tcm_top_asserts.sv
// checker for tcm_top: command handshake, drive select, parity and usage meters
// assumes it is bound into tcm_top and sees only its ports
`timescale 1ns/1ps
module tcm_top_asserts
    import tcm_pkg::*;
#(
    parameter int SEQ_LIMIT = 2500
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_accept,
    input wire logic device_end,
    input wire logic busy_ind,
    input wire logic online,
    input wire logic metering_req,
    input wire logic [tcm_pkg::TCM_METER_W-1:0] unit_meter,
    input wire logic [tcm_pkg::TCM_DRIVES*tcm_pkg::TCM_METER_W-1:0] drive_meter,
    input wire logic [tcm_pkg::TCM_DRIVES-1:0] drv_sel,
    input wire logic drv_wr_valid,
    input wire logic [8:0] drv_wr_data,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    input wire logic in_par
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_accept_pulse: assert property (cmd_accept |=> !cmd_accept)
        else $error("accept too long");
    a_busy_rise: assert property ($rose(busy_ind) |-> cmd_accept || $past(cmd_accept))
        else $error("busy without accept");
    a_busy_drop: assert property ($fell(busy_ind) |-> device_end)
        else $error("busy fell early");
    a_sel_onehot: assert property (drv_sel != 8'h00 |-> $onehot(drv_sel))
        else $error("two drives selected");
    a_sel_hold: assert property (busy_ind && $past(busy_ind) |-> $stable(drv_sel))
        else $error("drive changed mid command");
    a_wr_parity: assert property (drv_wr_valid |-> ^drv_wr_data)
        else $error("drive byte parity even");
    a_in_parity: assert property (in_valid |-> ^{in_par, in_byte})
        else $error("host byte parity even");
    a_meter_step: assert property (unit_meter != $past(unit_meter) |-> unit_meter == $past(unit_meter) + 32'h0000_0001)
        else $error("meter jumped");
    a_meter_offline: assert property (!online && !$past(online) && !$past(online, 2) |-> $stable(unit_meter) && $stable(drive_meter))
        else $error("meter ran offline");
    a_meter_noreq: assert property (!metering_req && !$past(metering_req) && !$past(metering_req, 2) |-> $stable(unit_meter))
        else $error("meter ran without request");
endmodule : tcm_top_asserts

bind tcm_top tcm_top_asserts #(.SEQ_LIMIT(SEQ_LIMIT)) u_chk (.clk(clk), .rst_n(rst_n), .cmd_accept(cmd_accept),
    .device_end(device_end), .busy_ind(busy_ind), .online(online), .metering_req(metering_req),
    .unit_meter(unit_meter), .drive_meter(drive_meter), .drv_sel(drv_sel), .drv_wr_valid(drv_wr_valid),
    .drv_wr_data(drv_wr_data), .in_valid(in_valid), .in_byte(in_byte), .in_par(in_par));

//--- bench/tcm_top_bench.sv
// self-checking bench for tcm_top: commands, burst writes, reads, sense, fifo fill, meters
// assumes tcm_drive_model on the drive side; the bench acts as the host channel
`timescale 1ns/1ps
module tcm_top_bench;
    import tcm_pkg::*;
    localparam logic [7:0] own_addr = 8'h3A;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, dual_fitted = 1'b0, online_sw_a = 1'b1, online_sw_b = 1'b0;
    logic cmd_valid = 1'b0, cmd_par = 1'b0, burst_hold = 1'b0, out_valid = 1'b0, out_par = 1'b0, in_ready = 1'b1;
    logic metering_req = 1'b0, stall = 1'b0, rd_bad = 1'b0;
    logic [7:0] jumper_addr = own_addr, cmd_addr = 8'h00, cmd_byte = 8'h00, out_byte = 8'h00;
    logic [7:0] drv_loaded = 8'h00, drv_at_lp = 8'h00;
    logic [2:0] cmd_drive = 3'h0;
    logic out_ready, in_valid, in_par, cmd_accept, device_end, busy_ind, seq_long, online, drv_wr_valid;
    logic drv_wr_ready, drv_rd_valid, drv_rd_last, drv_op_done, drv_start, drv_dir_wr;
    logic [7:0] in_byte, unit_status, drv_sel, wr_cnt, bad_cnt;
    logic [8:0] drv_wr_data, drv_rd_data;
    logic [31:0] unit_meter;
    logic [255:0] drive_meter;
    int failures = 0;
    int checked = 0;
    int n;
    always #10 clk = ~clk;
    tcm_top #(.SEQ_LIMIT(20)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .jumper_addr(jumper_addr),
        .dual_fitted(dual_fitted), .online_sw_a(online_sw_a), .online_sw_b(online_sw_b), .cmd_valid(cmd_valid),
        .cmd_addr(cmd_addr), .cmd_byte(cmd_byte), .cmd_par(cmd_par), .cmd_drive(cmd_drive), .burst_hold(burst_hold),
        .out_valid(out_valid), .out_byte(out_byte), .out_par(out_par), .out_ready(out_ready), .in_valid(in_valid),
        .in_byte(in_byte), .in_par(in_par), .in_ready(in_ready), .cmd_accept(cmd_accept), .device_end(device_end),
        .unit_status(unit_status), .busy_ind(busy_ind), .seq_long(seq_long), .metering_req(metering_req),
        .online(online), .unit_meter(unit_meter), .drive_meter(drive_meter), .drv_sel(drv_sel),
        .drv_wr_valid(drv_wr_valid), .drv_wr_data(drv_wr_data), .drv_wr_ready(drv_wr_ready),
        .drv_rd_valid(drv_rd_valid), .drv_rd_data(drv_rd_data), .drv_rd_last(drv_rd_last),
        .drv_op_done(drv_op_done), .drv_loaded(drv_loaded), .drv_at_lp(drv_at_lp), .drv_start(drv_start),
        .drv_dir_wr(drv_dir_wr));
    tcm_drive_model u_drv (.clk(clk), .drv_start(drv_start), .drv_dir_wr(drv_dir_wr), .drv_wr_valid(drv_wr_valid),
        .drv_wr_data(drv_wr_data), .stall(stall), .rd_bad(rd_bad), .drv_wr_ready(drv_wr_ready),
        .drv_rd_valid(drv_rd_valid), .drv_rd_data(drv_rd_data), .drv_rd_last(drv_rd_last),
        .drv_op_done(drv_op_done), .wr_cnt(wr_cnt), .bad_cnt(bad_cnt));
    task automatic report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic to(input logic ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t wait ran out", $time);
            report_and_stop();
        end
    endtask : to
    task automatic cmd(input logic [7:0] a, input logic [7:0] c, input logic bad, input logic [2:0] d, input logic acc);
        cmd_addr = a;
        cmd_byte = c;
        cmd_par = ~^c ^ bad;
        cmd_drive = d;
        cmd_valid = 1'b1;
        for (n = 0; n < 8 && cmd_accept !== 1'b1; n++) @(negedge clk);
        cmd_valid = 1'b0;
        chk({31'h0000_0000, cmd_accept === 1'b1}, {31'h0000_0000, acc});
    endtask : cmd
    task automatic wait_de(input logic [7:0] st);
        for (n = 0; n < 400 && device_end !== 1'b1; n++) @(negedge clk);
        to(device_end === 1'b1);
        chk(unit_status, st);
        @(negedge clk);
        chk(busy_ind, 1'b0);
    endtask : wait_de
    task automatic rd_in(input logic [7:0] exp);
        for (n = 0; n < 40 && in_valid !== 1'b1; n++) @(negedge clk);
        to(in_valid === 1'b1);
        chk(in_byte, exp);
        chk(^{in_par, in_byte}, 1'b1);
        @(negedge clk);
    endtask : rd_in
    task automatic wbyte(input logic [7:0] b);
        out_valid = 1'b1;
        out_byte = b;
        out_par = ~^b;
        for (n = 0; n < 40 && out_ready !== 1'b1; n++) @(negedge clk);
        to(out_ready === 1'b1);
        @(negedge clk);
    endtask : wbyte
    task automatic sense(input logic [7:0] code);
        cmd(own_addr, TCM_CMD_SENSE, 1'b0, 3'h0, 1'b1);
        rd_in(code);
        wait_de(8'h00);
    endtask : sense
    task automatic meter(input logic [31:0] eu, input logic [31:0] e0, input logic [31:0] e1);
        logic [95:0] s;
        repeat (10) @(negedge clk);
        s = {unit_meter, drive_meter[63:0]};
        repeat (500) @(negedge clk);
        chk(unit_meter - s[95:64], eu);
        chk(drive_meter[31:0] - s[31:0], e0);
        chk(drive_meter[63:32] - s[63:32], e1);
    endtask : meter
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(online, 1'b1);
        cmd(8'h11, TCM_CMD_WRITE, 1'b0, 3'h5, 1'b0);
        @(negedge clk);
        cmd(own_addr, TCM_CMD_WRITE, 1'b0, 3'h5, 1'b1);
        chk(drv_sel, 8'h20);
        burst_hold = 1'b1;
        wbyte(8'h5A);
        chk(busy_ind, 1'b1);
        chk(drv_dir_wr, 1'b1);
        chk(seq_long, 1'b0);
        wbyte(8'hC3);
        wbyte(8'h81);
        out_valid = 1'b0;
        burst_hold = 1'b0;
        wait_de(8'h00);
        chk(wr_cnt, 8'h03);
        chk(bad_cnt, 8'h00);
        for (int k = 0; k < 2; k++) begin
            rd_bad = k[0];
            cmd(own_addr, k ? TCM_CMD_READB : TCM_CMD_READF, 1'b0, k ? 3'h1 : 3'h7, 1'b1);
            chk(drv_sel, k ? 8'h02 : 8'h80);
            for (int i = 0; i < 4; i++) rd_in(8'hA0 + i[7:0]);
            wait_de(k ? 8'h02 : 8'h00);
            sense(k ? TCM_SENSE_PAR : TCM_SENSE_OK);
        end
        for (int k = 0; k < 2; k++) begin
            cmd(own_addr, k ? 8'hFF : TCM_CMD_WRITE, k == 0, 3'h0, 1'b1);
            wait_de(8'h02);
            sense(k ? TCM_SENSE_REJ : TCM_SENSE_PAR);
        end
        stall = 1'b1;
        cmd(own_addr, TCM_CMD_WRITE, 1'b0, 3'h2, 1'b1);
        burst_hold = 1'b1;
        out_valid = 1'b1;
        for (n = 0; n < 30; n++) begin
            out_byte = n[7:0];
            out_par = ~^out_byte ^ (n == 0);
            if (out_ready !== 1'b1) break;
            @(negedge clk);
        end
        chk({31'h0000_0000, n >= 16 && n < 30}, 32'h0000_0001);
        repeat (10) @(negedge clk);
        chk(seq_long, 1'b1);
        out_valid = 1'b0;
        burst_hold = 1'b0;
        stall = 1'b0;
        wait_de(8'h02);
        chk(bad_cnt, 8'h00);
        metering_req = 1'b1;
        drv_loaded = 8'h03;
        drv_at_lp = 8'h02;
        meter(32'h0000_000A, 32'h0000_000A, 32'h0000_0000);
        ce = 1'b0;
        meter(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        ce = 1'b1;
        online_sw_a = 1'b0;
        meter(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        chk(online, 1'b0);
        cmd(own_addr, TCM_CMD_SENSE, 1'b0, 3'h0, 1'b0);
        online_sw_a = 1'b1;
        metering_req = 1'b0;
        meter(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        dual_fitted = 1'b1;
        repeat (3) @(negedge clk);
        chk(online, 1'b0);
        online_sw_b = 1'b1;
        repeat (3) @(negedge clk);
        chk(online, 1'b1);
        report_and_stop();
    end
endmodule : tcm_top_bench

//--- rtl/tcm_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes single clock, synchronous inputs
`timescale 1ns/1ps
module tcm_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [W-1:0] mem_d [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic wr, rd;

    always_comb begin
        in_ready = cnt_q != (AW+1)'(D);
        out_valid = cnt_q != '0;
        out_data = mem_q[rp_q];
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        wp_d = wr ? wp_q + AW'(1) : wp_q;
        rp_d = rd ? rp_q + AW'(1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
        if (flush) begin
            wp_d = '0;
            rp_d = '0;
            cnt_d = '0;
        end
    end

    generate
        for (genvar i = 0; i < D; i++) begin : g_ent
            always_comb begin
                mem_d[i] = (wr && wp_q == AW'(i)) ? in_data : mem_q[i];
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[i] <= '0;
                end else if (ce) begin
                    mem_q[i] <= mem_d[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : tcm_fifo

//--- rtl/tcm_pkg.sv
// package for the tape control channel block: widths, codes, reset values, timing
// assumes a 50 MHz clock; shared by the top module, its checker and the bench
package tcm_pkg;
    localparam int TCM_DRIVES = 8;
    localparam int TCM_DRV_W = 3;
    localparam int TCM_FIFO_W = 9;
    localparam int TCM_FIFO_D = 16;
    localparam int TCM_CLK_MHZ = 50;
    localparam int TCM_SEQ_US = 32;
    localparam int TCM_SEQ_US_7T = 50;
    localparam int TCM_SEQ_CYC = TCM_SEQ_US * TCM_CLK_MHZ;
    localparam int TCM_SEQ_CYC_7T = TCM_SEQ_US_7T * TCM_CLK_MHZ;
    localparam int TCM_TICK_W = 12;
    localparam int TCM_TICK_CYC = 50;
    localparam logic [TCM_TICK_W-1:0] TCM_TICK_LAST = 12'h0_031;
    localparam int TCM_METER_W = 32;
    localparam logic [TCM_METER_W-1:0] TCM_METER_RST = 32'h0000_0000;
    localparam logic [7:0] TCM_CMD_WRITE = 8'h01;
    localparam logic [7:0] TCM_CMD_READF = 8'h02;
    localparam logic [7:0] TCM_CMD_SENSE = 8'h04;
    localparam logic [7:0] TCM_CMD_READB = 8'h0C;
    localparam logic [7:0] TCM_SENSE_OK = 8'h00;
    localparam logic [7:0] TCM_SENSE_PAR = 8'h40;
    localparam logic [7:0] TCM_SENSE_REJ = 8'h80;
    typedef enum logic [2:0] {
        TCM_CH_IDLE, TCM_CH_OUT, TCM_CH_IN, TCM_CH_SENSE, TCM_CH_END
    } tcm_ch_e;
    typedef enum logic [1:0] {
        TCM_DV_IDLE, TCM_DV_RUN, TCM_DV_DONE
    } tcm_dv_e;
endpackage : tcm_pkg

//--- rtl/tcm_top.sv
// tape control channel side: command intake, burst data, parity, drive select, metering
// assumes synchronous channel and drive inputs on clk; host holds channel in burst
// Notes on behaviour
// - one command, one drive, until done
// - data moves in burst, channel held
// - parity checked on every data byte
// - write: check bus-out parity, regenerate for drive
// - read: check drive parity, regenerate for host
// - sense bytes carry generated correct parity
// - command bytes are parity checked
// - separate channel and drive sequencers
// - own address from jumper inputs only
// - drive address is its port number
// - unit meter: metering request and online
// - drive meter: request, loaded, off load point
// - busy indicator from accept to device end
// - one switch takes unit and drives offline
// - offline inhibits every usage meter
// - second online switch when dual-channel fitted
// - sequences may exceed 32 us, 50 us bound
// - at most eight drives, one per port
`timescale 1ns/1ps
module tcm_top
    import tcm_pkg::*;
#(
    parameter int SEQ_LIMIT = tcm_pkg::TCM_SEQ_CYC_7T
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] jumper_addr,
    input wire logic dual_fitted,
    input wire logic online_sw_a,
    input wire logic online_sw_b,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_par,
    input wire logic [tcm_pkg::TCM_DRV_W-1:0] cmd_drive,
    input wire logic burst_hold,
    input wire logic out_valid,
    input wire logic [7:0] out_byte,
    input wire logic out_par,
    output logic out_ready,
    output logic in_valid,
    output logic [7:0] in_byte,
    output logic in_par,
    input wire logic in_ready,
    output logic cmd_accept,
    output logic device_end,
    output logic [7:0] unit_status,
    output logic busy_ind,
    output logic seq_long,
    input wire logic metering_req,
    output logic online,
    output logic [tcm_pkg::TCM_METER_W-1:0] unit_meter,
    output logic [tcm_pkg::TCM_DRIVES*tcm_pkg::TCM_METER_W-1:0] drive_meter,
    output logic [tcm_pkg::TCM_DRIVES-1:0] drv_sel,
    output logic drv_wr_valid,
    output logic [8:0] drv_wr_data,
    input wire logic drv_wr_ready,
    input wire logic drv_rd_valid,
    input wire logic [8:0] drv_rd_data,
    input wire logic drv_rd_last,
    input wire logic drv_op_done,
    input wire logic [tcm_pkg::TCM_DRIVES-1:0] drv_loaded,
    input wire logic [tcm_pkg::TCM_DRIVES-1:0] drv_at_lp,
    output logic drv_start,
    output logic drv_dir_wr
);
    import tcm_pkg::*;

    tcm_ch_e ch_q, ch_d;
    tcm_dv_e dv_q, dv_d;
    logic [7:0] cmd_q, cmd_d, sense_q, sense_d, status_q, status_d;
    logic [TCM_DRV_W-1:0] drv_q, drv_d;
    logic [TCM_DRIVES-1:0] sel_q, sel_d;
    logic busy_q, busy_d, acc_q, acc_d, de_q, de_d, start_q, start_d, dirw_q, dirw_d;
    logic online_q, online_d, slong_q, slong_d;
    logic [15:0] seq_q, seq_d;
    logic iv_q, iv_d, ip_q, ip_d;
    logic [7:0] ib_q, ib_d;
    logic wv_q, wv_d;
    logic [8:0] wd_q, wd_d;
    logic [TCM_TICK_W-1:0] tick_q, tick_d;
    logic [TCM_METER_W-1:0] um_q, um_d;
    logic [TCM_METER_W-1:0] dm_q [TCM_DRIVES];
    logic [TCM_METER_W-1:0] dm_d [TCM_DRIVES];
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush, tick;
    logic [8:0] f_in_data, f_out_data;
    logic is_wr, is_rd, cmd_ok, sw_on, par_err;

    // write data path buffer toward the drive
    tcm_fifo #(.W(TCM_FIFO_W), .D(TCM_FIFO_D)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .flush(f_flush),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // channel sequencer, one store of control
    always_comb begin
        ch_d = ch_q;
        cmd_d = cmd_q;
        drv_d = drv_q;
        sel_d = sel_q;
        busy_d = busy_q;
        acc_d = 1'b0;
        start_d = 1'b0;
        dirw_d = dirw_q;
        sense_d = sense_q;
        status_d = status_q;
        iv_d = iv_q;
        ib_d = ib_q;
        ip_d = ip_q;
        par_err = 1'b0;
        is_wr = cmd_byte == TCM_CMD_WRITE;
        is_rd = cmd_byte == TCM_CMD_READF || cmd_byte == TCM_CMD_READB;
        cmd_ok = is_wr || is_rd || cmd_byte == TCM_CMD_SENSE;
        f_in_valid = 1'b0;
        f_in_data = '0;
        f_flush = 1'b0;
        if (iv_q && in_ready) begin
            iv_d = 1'b0;
        end
        case (ch_q)
            TCM_CH_IDLE: begin
                // own address only from jumpers
                if (cmd_valid && online_q && cmd_addr == jumper_addr) begin
                    acc_d = 1'b1;
                    busy_d = 1'b1;
                    cmd_d = cmd_byte;
                    drv_d = cmd_drive;
                    // drive picked by its port number alone
                    sel_d = TCM_DRIVES'(1) << cmd_drive;
                    status_d = '0;
                    f_flush = 1'b1;
                    // command byte parity, odd
                    if (^{cmd_byte, cmd_par} != 1'b1) begin
                        sense_d = TCM_SENSE_PAR;
                        status_d = 8'h02;
                        ch_d = TCM_CH_END;
                    end else if (!cmd_ok) begin
                        sense_d = TCM_SENSE_REJ;
                        status_d = 8'h02;
                        ch_d = TCM_CH_END;
                    end else if (cmd_byte == TCM_CMD_SENSE) begin
                        ch_d = TCM_CH_SENSE;
                    end else begin
                        sense_d = TCM_SENSE_OK;
                        start_d = 1'b1;
                        dirw_d = is_wr;
                        ch_d = is_wr ? TCM_CH_OUT : TCM_CH_IN;
                    end
                end
            end
            TCM_CH_OUT: begin
                // burst write: check bus-out parity, regenerate
                if (out_valid && f_in_ready) begin
                    f_in_valid = 1'b1;
                    f_in_data = {~^out_byte, out_byte};
                    if (^{out_byte, out_par} != 1'b1) begin
                        par_err = 1'b1;
                    end
                end
                if (!burst_hold && !out_valid) begin
                    ch_d = TCM_CH_END;
                end
            end
            TCM_CH_IN: begin
                // burst read: check drive parity, regenerate
                if (drv_rd_valid && (!iv_q || in_ready)) begin
                    iv_d = 1'b1;
                    ib_d = drv_rd_data[7:0];
                    ip_d = ~^drv_rd_data[7:0];
                    if (^drv_rd_data != 1'b1) begin
                        par_err = 1'b1;
                    end
                end
                if (drv_rd_last && drv_rd_valid) begin
                    ch_d = TCM_CH_END;
                end
            end
            TCM_CH_SENSE: begin
                // one sense byte with generated parity
                if (!iv_q) begin
                    iv_d = 1'b1;
                    ib_d = sense_q;
                    ip_d = ~^sense_q;
                    ch_d = TCM_CH_END;
                end
            end
            default: begin
                // wait for drive side and drained output
                if (!iv_q && !wv_q && (dv_q == TCM_DV_IDLE || dv_q == TCM_DV_DONE) && !f_out_valid) begin
                    busy_d = 1'b0;
                    sel_d = '0;
                    ch_d = TCM_CH_IDLE;
                end
            end
        endcase
        if (par_err) begin
            sense_d = TCM_SENSE_PAR;
            status_d = 8'h02;
        end
    end

    // drive sequencer, second independent store
    always_comb begin
        dv_d = dv_q;
        f_out_ready = 1'b0;
        wv_d = wv_q;
        wd_d = wd_q;
        de_d = 1'b0;
        if (wv_q && drv_wr_ready) begin
            wv_d = 1'b0;
        end
        case (dv_q)
            TCM_DV_IDLE: begin
                if (start_q) begin
                    dv_d = TCM_DV_RUN;
                end
            end
            TCM_DV_RUN: begin
                if (dirw_q && f_out_valid && (!wv_q || drv_wr_ready)) begin
                    f_out_ready = 1'b1;
                    wv_d = 1'b1;
                    wd_d = f_out_data;
                end
                if (drv_op_done) begin
                    dv_d = TCM_DV_DONE;
                end
            end
            default: begin
                if (ch_q == TCM_CH_END && !f_out_valid && !wv_q && !iv_q) begin
                    de_d = 1'b1;
                    dv_d = TCM_DV_IDLE;
                end
            end
        endcase
        if (ch_q == TCM_CH_END && dv_q == TCM_DV_IDLE && busy_q && !iv_q && !wv_q && !f_out_valid) begin
            de_d = 1'b1;
        end
    end

    // online switch(es), long-sequence watch, meters
    always_comb begin
        sw_on = online_sw_a && (!dual_fitted || online_sw_b);
        online_d = sw_on;
        seq_d = (busy_q && seq_q != 16'hFFFF) ? seq_q + 16'h0_001 : 16'h0_000;
        slong_d = busy_q && 32'(seq_q) >= SEQ_LIMIT;
        tick = tick_q == TCM_TICK_LAST;
        tick_d = (metering_req && online_q) ? (tick ? '0 : tick_q + TCM_TICK_W'(1)) : tick_q;
        um_d = um_q + TCM_METER_W'(metering_req && online_q && tick);
    end

    generate
        for (genvar i = 0; i < TCM_DRIVES; i++) begin : g_drv
            always_comb begin
                dm_d[i] = dm_q[i] + TCM_METER_W'(metering_req && online_q && tick
                                                 && drv_loaded[i] && !drv_at_lp[i]);
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    dm_q[i] <= TCM_METER_RST;
                end else if (ce) begin
                    dm_q[i] <= dm_d[i];
                end
            end
            assign drive_meter[i*TCM_METER_W +: TCM_METER_W] = dm_q[i];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_q <= TCM_CH_IDLE;
            dv_q <= TCM_DV_IDLE;
            cmd_q <= '0;
            drv_q <= '0;
            sel_q <= '0;
            busy_q <= 1'b0;
            acc_q <= 1'b0;
            de_q <= 1'b0;
            start_q <= 1'b0;
            dirw_q <= 1'b0;
            sense_q <= TCM_SENSE_OK;
            status_q <= '0;
            iv_q <= 1'b0;
            ib_q <= '0;
            ip_q <= 1'b0;
            wv_q <= 1'b0;
            wd_q <= '0;
            online_q <= 1'b0;
            slong_q <= 1'b0;
            seq_q <= '0;
            tick_q <= '0;
            um_q <= TCM_METER_RST;
        end else if (ce) begin
            ch_q <= ch_d;
            dv_q <= dv_d;
            cmd_q <= cmd_d;
            drv_q <= drv_d;
            sel_q <= sel_d;
            busy_q <= busy_d;
            acc_q <= acc_d;
            de_q <= de_d;
            start_q <= start_d;
            dirw_q <= dirw_d;
            sense_q <= sense_d;
            status_q <= status_d;
            iv_q <= iv_d;
            ib_q <= ib_d;
            ip_q <= ip_d;
            wv_q <= wv_d;
            wd_q <= wd_d;
            online_q <= online_d;
            slong_q <= slong_d;
            seq_q <= seq_d;
            tick_q <= tick_d;
            um_q <= um_d;
        end
    end

    assign out_ready = ch_q == TCM_CH_OUT && f_in_ready && ce;
    assign in_valid = iv_q;
    assign in_byte = ib_q;
    assign in_par = ip_q;
    assign cmd_accept = acc_q;
    assign device_end = de_q;
    assign unit_status = status_q;
    assign busy_ind = busy_q;
    assign seq_long = slong_q;
    assign online = online_q;
    assign unit_meter = um_q;
    assign drv_sel = sel_q;
    assign drv_wr_valid = wv_q;
    assign drv_wr_data = wd_q;
    assign drv_start = start_q;
    assign drv_dir_wr = dirw_q;
endmodule : tcm_top
